// ==== pkg/cis_consts.vh ====
// Constants for the CPU interrupt sequencer.
// Function
// - Sample pending requests at instruction end, mask clear
// - Highest priority pending request serviced first
// - Pending request taken again before next instruction
// - Return always prefetches the next opcode
// - Upper index byte never stacked on entry
// - Software trap always interrupts, mask ignored
// - Trap stacks PC, hardware stacks PC minus one
// - Break address match forces a software trap
// - Global mask blocks all but software trap
// - Priority zero highest; reset top, trap below
// - Sources 1..20, vectors descend two per priority
`ifndef CIS_CONSTS_VH
`define CIS_CONSTS_VH
`define CIS_NSRC 20
`define CIS_VEC_RESET 16'hFFFE
`define CIS_VEC_TRAP 16'hFFFC
`define CIS_VEC_SRC1 16'hFFFA
`define CIS_ST_IDLE 3'h0
`define CIS_ST_PCL 3'h1
`define CIS_ST_PCH 3'h2
`define CIS_ST_XR 3'h3
`define CIS_ST_AR 3'h4
`define CIS_ST_CCR 3'h5
`define CIS_ST_VHI 3'h6
`define CIS_ST_VLO 3'h7
`define CIS_KIND_STACK 2'h1
`define CIS_KIND_FETCH 2'h2
`endif

// ==== hw/cis_sequencer.v ====
// Interrupt recognition and entry sequencing for the CPU core.
`timescale 1ns/1ps
`default_nettype none
`include "cis_consts.vh"

// One source's request, folded from the conditions that share its vector.
module cis_source_req #(
   parameter CPS = 4
) (
   input wire [CPS-1:0] condFlag,
   input wire [CPS-1:0] condEnable,
   output wire request
);
   // Shared conditions are simply ORed, so the service routine must poll the flags to tell
   // them apart.
   assign request = |(condFlag & condEnable);
endmodule

module cis_sequencer #(
   parameter NSRC = `CIS_NSRC,
   parameter CPS = 4
) (
   input wire ref_clk,
   input wire srst,
   input wire [NSRC*CPS-1:0] condFlag,
   input wire [NSRC*CPS-1:0] condEnable,
   input wire instrDone,
   input wire maskBit,
   input wire trapExec,
   input wire returnDone,
   input wire [15:0] pcValue,
   input wire [7:0] accValue,
   input wire [7:0] idxLowValue,
   input wire [7:0] ccrValue,
   input wire breakEnable,
   input wire [15:0] breakAddr,
   input wire [15:0] fetchAddr,
   output reg [NSRC:1] sourceRequestFlag_r,
   output reg busy_r,
   output reg setMask_r,
   output reg forceTrap_r,
   output reg prefetch_r,
   output reg [1:0] cycKind_r,
   output reg [15:0] cycAddr_r,
   output reg [7:0] stackData_r,
   output reg [15:0] pcLoad_r,
   output reg pcLoadValid_r
);
   localparam [2:0] ST_IDLE = `CIS_ST_IDLE;
   localparam [2:0] ST_PCL = `CIS_ST_PCL;
   localparam [2:0] ST_PCH = `CIS_ST_PCH;
   localparam [2:0] ST_XR = `CIS_ST_XR;
   localparam [2:0] ST_AR = `CIS_ST_AR;
   localparam [2:0] ST_CCR = `CIS_ST_CCR;
   localparam [2:0] ST_VHI = `CIS_ST_VHI;
   localparam [2:0] ST_VLO = `CIS_ST_VLO;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [15:0] savePc_r;
   reg [15:0] vecAddr_r;
   wire [NSRC:1] req;
   reg [15:0] selVec;
   reg [15:0] vecOffset;
   reg anyReq;
   wire takeTrap;
   wire takeHw;
   integer i;
   genvar g;

   // Each source folds its shared conditions in an instance of its own.
   generate
      for (g = 1; g <= NSRC; g = g + 1) begin : gen_src
         cis_source_req #(
            .CPS(CPS)
         ) u_src (
            .condFlag(condFlag[(g-1)*CPS +: CPS]),
            .condEnable(condEnable[(g-1)*CPS +: CPS]),
            .request(req[g])
         );
      end
   endgenerate

   // Scan from lowest priority up so the highest-priority source wins last.
   always @* begin
      anyReq = 1'b0;
      selVec = `CIS_VEC_SRC1;
      vecOffset = 16'h0000;
      for (i = NSRC; i >= 1; i = i - 1) begin
         if (req[i]) begin
            anyReq = 1'b1;
            // Two bytes per priority step below the first source vector.
            vecOffset = {i[14:0], 1'b0} - 16'h0002;
            selVec = `CIS_VEC_SRC1 - vecOffset;
         end
      end
   end

   // The trap ignores the global mask; hardware sources only enter at a boundary.
   assign takeTrap = trapExec && !busy_r;
   assign takeHw = (instrDone || returnDone) && !maskBit && anyReq && !busy_r;

   always @* begin
      case (state_r)
         ST_IDLE: begin
            state_nxt = ST_IDLE;
         end
         ST_PCL: begin
            state_nxt = ST_PCH;
         end
         ST_PCH: begin
            // The upper index byte is skipped on purpose.
            state_nxt = ST_XR;
         end
         ST_XR: begin
            state_nxt = ST_AR;
         end
         ST_AR: begin
            state_nxt = ST_CCR;
         end
         ST_CCR: begin
            state_nxt = ST_VHI;
         end
         ST_VHI: begin
            state_nxt = ST_VLO;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         savePc_r <= 16'h0000;
         vecAddr_r <= `CIS_VEC_RESET;
         sourceRequestFlag_r <= {NSRC{1'b0}};
         busy_r <= 1'b0;
         setMask_r <= 1'b0;
         forceTrap_r <= 1'b0;
         prefetch_r <= 1'b0;
         cycKind_r <= 2'h0;
         cycAddr_r <= 16'h0000;
         stackData_r <= 8'h00;
         pcLoad_r <= 16'h0000;
         pcLoadValid_r <= 1'b0;
      end else begin
         sourceRequestFlag_r <= req;
         setMask_r <= 1'b0;
         pcLoadValid_r <= 1'b0;
         cycKind_r <= 2'h0;
         // Break match turns the fetch into a trap opcode for the core.
         forceTrap_r <= breakEnable && (fetchAddr == breakAddr);
         // Return always prefetches, even if an interrupt follows at once.
         prefetch_r <= returnDone;
         if (state_r == ST_IDLE) begin
            busy_r <= 1'b0;
            // A trap beats a hardware request seen at the same boundary.
            if (takeTrap) begin
               state_r <= ST_PCL;
               savePc_r <= pcValue;
               vecAddr_r <= `CIS_VEC_TRAP;
               busy_r <= 1'b1;
            end else if (takeHw) begin
               state_r <= ST_PCL;
               savePc_r <= pcValue - 16'h0001;
               vecAddr_r <= selVec;
               busy_r <= 1'b1;
            end
         end else begin
            state_r <= state_nxt;
            case (state_r)
               ST_PCL: begin
                  cycKind_r <= `CIS_KIND_STACK;
                  stackData_r <= savePc_r[7:0];
               end
               ST_PCH: begin
                  cycKind_r <= `CIS_KIND_STACK;
                  stackData_r <= savePc_r[15:8];
               end
               ST_XR: begin
                  cycKind_r <= `CIS_KIND_STACK;
                  stackData_r <= idxLowValue;
               end
               ST_AR: begin
                  cycKind_r <= `CIS_KIND_STACK;
                  stackData_r <= accValue;
               end
               ST_CCR: begin
                  cycKind_r <= `CIS_KIND_STACK;
                  stackData_r <= ccrValue;
                  // The mask is set in the same cycle that the old condition codes are stacked.
                  setMask_r <= 1'b1;
               end
               ST_VHI: begin
                  cycKind_r <= `CIS_KIND_FETCH;
                  cycAddr_r <= vecAddr_r;
               end
               ST_VLO: begin
                  cycKind_r <= `CIS_KIND_FETCH;
                  cycAddr_r <= vecAddr_r + 16'h0001;
                  pcLoad_r <= vecAddr_r;
                  pcLoadValid_r <= 1'b1;
               end
               default: begin
                  cycKind_r <= 2'h0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== bench/cis_assertions.sv ====
// Checker of interrupt entry timing and sequencer outputs.
`timescale 1ns/1ps
`default_nettype none
module cis_assertions (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic returnDone,
   input wire logic maskBit,
   input wire logic trapExec,
   input wire logic busy_r,
   input wire logic setMask_r,
   input wire logic prefetch_r,
   input wire logic [1:0] cycKind_r,
   input wire logic [15:0] pcLoad_r,
   input wire logic pcLoadValid_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_trap_taken: assert property (!busy_r && trapExec |=> busy_r) else $error("trap lost");
   a_mask_holds:
      assert property (!busy_r && maskBit && !trapExec |=> !busy_r) else $error("masked");
   a_entry_len: assert property ($rose(busy_r) |=> busy_r[*7] ##1 !busy_r) else $error("len");
   a_stack_count:
      assert property ($rose(busy_r) |=> (cycKind_r == 2'h1)[*5] ##1 (cycKind_r == 2'h2)[*2])
      else $error("stack");
   a_mask_set: assert property ($rose(busy_r) |-> ##5 setMask_r) else $error("mask set");
   a_vec_valid: assert property ($rose(busy_r) |-> ##7 pcLoadValid_r) else $error("vec");
   a_return_prefetch: assert property (returnDone |=> prefetch_r) else $error("fetch");
   a_vec_range:
      assert property (pcLoadValid_r |-> !pcLoad_r[0] && pcLoad_r >= 16'hFFD4) else $error("range");
   cover property (!busy_r && trapExec && maskBit);
   cover property (returnDone && !maskBit);
   cover property (pcLoadValid_r && pcLoad_r == 16'hFFEE);
endmodule
bind cis_sequencer cis_assertions u_chk (.*);
`default_nettype wire

// ==== bench/cis_core_model.sv ====
// Core-side model that retires instructions at a chosen spacing.
`timescale 1ns/1ps
`default_nettype none
module cis_core_model (
   input wire logic ref_clk,
   input wire logic busy_r,
   input wire logic [3:0] gap,
   output var logic instrDone = 1'b0
);
   // The core stalls while entry owns the bus, so nothing retires then.
   logic [3:0] cnt_r = 4'h0;
   always @(posedge ref_clk) begin
      cnt_r <= (busy_r || cnt_r == gap) ? 4'h0 : cnt_r + 4'h1;
      instrDone <= !busy_r && cnt_r == gap;
   end
endmodule
`default_nettype wire

// ==== bench/test_cpu_interrupt_sequencer.sv ====
// Self-checking bench of the interrupt sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin checks++; if ((a)!==(b)) begin err_count++; $display("BAD %0t diff",$time); end end
module test_cpu_interrupt_sequencer;
   logic ref_clk = 0, srst = 1, maskBit = 1, trapExec = 0, returnDone = 0, breakEnable = 0;
   logic instrDone, busy_r, setMask_r, forceTrap_r, prefetch_r, pcLoadValid_r;
   logic [79:0] condFlag = 80'h0, condEnable = 80'h0;
   logic [15:0] pcValue = 16'h1234, breakAddr = 16'h0200, fetchAddr = 16'h0200, cycAddr_r, pcLoad_r;
   logic [7:0] accValue = 8'h5A, idxLowValue = 8'hA5, ccrValue = 8'h0F, stackData_r;
   logic [20:1] sourceRequestFlag_r;
   logic [1:0] cycKind_r;
   logic [3:0] gap = 4'h0;
   int err_count = 0, checks = 0, cyc = 0;
   cis_sequencer uut (.*);
   cis_core_model core (.ref_clk(ref_clk), .busy_r(busy_r), .gap(gap), .instrDone(instrDone));
   initial forever #20 ref_clk = !ref_clk;
   always @(posedge ref_clk) if (++cyc == 3000) begin
      err_count++;
      conclude();
   end
   task conclude();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Follows one entry; the bench sets the global mask once stacking starts.
   task automatic entry(input logic [15:0] vec, input logic [7:0] pcl);
      int n = 0;
      do @(negedge ref_clk); while (cycKind_r !== 2'h1 && ++n < 40);
      `CHK(stackData_r, pcl)
      @(posedge ref_clk) maskBit <= 1'b1;
      @(negedge ref_clk);
      `CHK(stackData_r, pcValue[15:8])
      @(negedge ref_clk);
      `CHK(stackData_r, idxLowValue)
      @(negedge ref_clk);
      `CHK(stackData_r, accValue)
      @(negedge ref_clk);
      `CHK({setMask_r, stackData_r}, {1'b1, ccrValue})
      @(negedge ref_clk);
      `CHK({cycKind_r, cycAddr_r}, {2'h2, vec})
      @(negedge ref_clk);
      `CHK({pcLoadValid_r, cycAddr_r, pcLoad_r}, {1'b1, vec + 16'h0001, vec})
   endtask
   task t_trap();
      @(posedge ref_clk);
      condFlag <= 80'h0100_0100;
      condEnable <= 80'h0100_0100;
      repeat (8) @(negedge ref_clk);
      `CHK(busy_r, 1'b0)
      `CHK(sourceRequestFlag_r, 20'h0_0044)
      @(posedge ref_clk) trapExec <= 1'b1;
      @(posedge ref_clk) trapExec <= 1'b0;
      entry(16'hFFFC, 8'h34);
   endtask
   task t_prio();
      @(posedge ref_clk) maskBit <= 1'b0;
      entry(16'hFFF6, 8'h33);
      @(posedge ref_clk);
      condFlag <= 80'h0100_0000;
      gap <= 4'h5;
      repeat (2) @(posedge ref_clk);
      maskBit <= 1'b0;
      returnDone <= 1'b1;
      @(posedge ref_clk) returnDone <= 1'b0;
      entry(16'hFFEE, 8'h33);
   endtask
   task t_misc();
      @(posedge ref_clk) condFlag <= 80'h2_0000_0000;
      repeat (2) @(negedge ref_clk);
      `CHK(sourceRequestFlag_r[9], 1'b0)
      @(posedge ref_clk) condEnable <= 80'h2_0000_0000;
      repeat (2) @(negedge ref_clk);
      `CHK(sourceRequestFlag_r[9], 1'b1)
      @(posedge ref_clk) breakEnable <= 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK(forceTrap_r, 1'b1)
      @(posedge ref_clk) fetchAddr <= 16'h0202;
      repeat (2) @(negedge ref_clk);
      `CHK(forceTrap_r, 1'b0)
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      t_trap();
      t_prio();
      t_misc();
      conclude();
   end
endmodule
`default_nettype wire
